// ===== design/mevc_bank.v
// Four-channel event counter bank with APB register access.
// Expects pulse inputs synchronous to clk_in and one-cycle scan strobes
// from the acquisition sequencer.
`timescale 1ns/1ps
`include "mevc_map.vh"

module mevc_bank #(
  parameter NCH = 4,
  parameter DB_DIV = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire rstn_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // Pulse inputs
  input wire [NCH-1:0] cnt_pin_in,
  // Sequencer strobes
  input wire scan_start_in,
  input wire acq_start_in,
  // Scan sample slot port
  input wire slot_req_in,
  input wire [1:0] slot_ch_in,
  input wire slot_hi_in,
  output reg [15:0] slot_data_out,
  output reg slot_valid_out
);

  // Debounce interval table, cycles rounded up, shortened by DB_DIV
  function [`MEVC_DB_TW-1:0] db_cycles;
    input [3:0] idx;
    integer ns;
    integer cyc;
    begin
      ns = `MEVC_DB_T0_NS;
      case (idx)
        4'h0: ns = `MEVC_DB_T0_NS;
        4'h1: ns = `MEVC_DB_T1_NS;
        4'h2: ns = `MEVC_DB_T2_NS;
        4'h3: ns = `MEVC_DB_T3_NS;
        4'h4: ns = `MEVC_DB_T4_NS;
        4'h5: ns = `MEVC_DB_T5_NS;
        4'h6: ns = `MEVC_DB_T6_NS;
        4'h7: ns = `MEVC_DB_T7_NS;
        4'h8: ns = `MEVC_DB_T8_NS;
        4'h9: ns = `MEVC_DB_T9_NS;
        4'hA: ns = `MEVC_DB_T10_NS;
        4'hB: ns = `MEVC_DB_T11_NS;
        4'hC: ns = `MEVC_DB_T12_NS;
        4'hD: ns = `MEVC_DB_T13_NS;
        4'hE: ns = `MEVC_DB_T14_NS;
        default: ns = `MEVC_DB_T15_NS;
      endcase
      cyc = ((ns + `MEVC_CLK_NS - 1) / `MEVC_CLK_NS) / DB_DIV;
      if (cyc < 1) begin
        cyc = 1;
      end
      db_cycles = cyc[`MEVC_DB_TW-1:0];
    end
  endfunction

  // Saturation top for the chosen width
  function [31:0] sat_top;
    input w32;
    begin
      sat_top = w32 ? `MEVC_TOP32 : `MEVC_TOP16;
    end
  endfunction

  // Registers and per-channel state
  reg [31:0] cfg_reg [0:NCH-1];
  reg [31:0] cnt_reg [0:NCH-1];
  reg [31:0] cnt_next [0:NCH-1];
  reg [31:0] snap_reg [0:NCH-1];
  reg [31:0] latch_reg [0:NCH-1];
  reg [NCH-1:0] cond_last_reg;
  reg sync_reg;

  wire [NCH-1:0] cond_w;
  wire [NCH-1:0] rise_w;
  wire acc_w;
  wire wr_w;
  wire rd_w;
  wire is_ch_w;
  wire is_ctrl_w;
  wire bad_w;
  wire [1:0] ach_w;
  wire [1:0] aofs_w;

  // Conditioning path per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : cond_gen
      mevc_debounce u_db (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .raw_in(cnt_pin_in[g]),
        .invert_in(cfg_reg[g][`MEVC_F_INV]),
        .mode_in(cfg_reg[g][`MEVC_F_DBM]),
        .limit_in(db_cycles(cfg_reg[g][`MEVC_F_DBT])),
        .cond_out(cond_w[g])
      );
    end
  endgenerate

  // Active edges of the conditioned inputs
  assign rise_w = cond_w & ~cond_last_reg;

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      cond_last_reg <= {NCH{1'b0}};
    end else begin
      cond_last_reg <= cond_w;
    end
  end

  // APB decode; every access completes in its first access cycle
  assign acc_w = psel_in & penable_in;
  assign wr_w = acc_w & pwrite_in & ~bad_w;
  assign rd_w = acc_w & ~pwrite_in & ~bad_w;
  assign ach_w = paddr_in[5:4];
  assign aofs_w = paddr_in[3:2];
  assign is_ch_w = (paddr_in[7:6] == 2'h0);
  assign is_ctrl_w = (paddr_in == `MEVC_ADDR_CTRL);
  assign bad_w = (paddr_in[1:0] != 2'h0) | ~(is_ch_w | is_ctrl_w);
  assign pready_out = 1'b1;
  assign pslverr_out = acc_w & bad_w;

  // Read data mux; the low half returns the live count being captured
  always @* begin
    prdata_out = 32'h00000000;
    if (psel_in && !bad_w && is_ctrl_w) begin
      prdata_out = {31'h00000000, sync_reg};
    end else if (psel_in && !bad_w) begin
      case (aofs_w)
        `MEVC_OFS_CFG: prdata_out = cfg_reg[ach_w];
        `MEVC_OFS_LO: prdata_out = {16'h0000, cnt_reg[ach_w][15:0]};
        `MEVC_OFS_HI: prdata_out = {16'h0000, snap_reg[ach_w][31:16]};
        default: prdata_out = latch_reg[ach_w];
      endcase
    end
  end

  // Counter next-state per channel
  integer i;
  reg [1:0] m_sel;
  reg m_level;
  reg m_rise;
  reg inc;
  reg dec;
  reg [1:0] mode;
  reg lo_read;
  always @* begin
    m_sel = 2'h0;
    m_level = 1'b0;
    m_rise = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    mode = `MEVC_MODE_TOT;
    lo_read = 1'b0;
    for (i = 0; i < NCH; i = i + 1) begin
      m_sel = cfg_reg[i][`MEVC_F_MAP];
      m_level = cond_w[m_sel];
      m_rise = rise_w[m_sel];
      mode = cfg_reg[i][`MEVC_F_MODE];
      // Gating only suspends counting; the held value is kept
      inc = rise_w[i] & (~cfg_reg[i][`MEVC_F_GATE] | m_level);
      dec = cfg_reg[i][`MEVC_F_DEC] & m_rise;
      lo_read = rd_w & is_ch_w & (ach_w == i[1:0]) & (aofs_w == `MEVC_OFS_LO);
      cnt_next[i] = cnt_reg[i];
      if (acq_start_in) begin
        cnt_next[i] = 32'h00000000;
      end else if (mode == `MEVC_MODE_COR && lo_read && !sync_reg) begin
        // A pulse in the clearing cycle is kept as the first new count
        cnt_next[i] = {31'h00000000, inc & ~dec};
      end else if (inc && !dec) begin
        if (mode == `MEVC_MODE_SAT) begin
          if (cnt_reg[i] != sat_top(cfg_reg[i][`MEVC_F_W32])) begin
            cnt_next[i] = cnt_reg[i] + 32'h00000001;
          end
        end else begin
          // Natural 32-bit wrap; the low word alone wraps at 16 bits
          cnt_next[i] = cnt_reg[i] + 32'h00000001;
        end
      end else if (dec && !inc) begin
        if (mode != `MEVC_MODE_TOT || cfg_reg[i][`MEVC_F_DEC]) begin
          cnt_next[i] = cnt_reg[i] - 32'h00000001;
        end
      end
    end
  end

  // Configuration, counters, captures and latches
  integer k;
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      sync_reg <= 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        cfg_reg[k] <= `MEVC_CFG_RST;
        cnt_reg[k] <= 32'h00000000;
        snap_reg[k] <= 32'h00000000;
        latch_reg[k] <= 32'h00000000;
      end
    end else begin
      if (wr_w && is_ctrl_w) begin
        sync_reg <= pwdata_in[`MEVC_F_SYNC];
      end
      for (k = 0; k < NCH; k = k + 1) begin
        cnt_reg[k] <= cnt_next[k];
        if (wr_w && is_ch_w && ach_w == k[1:0] && aofs_w == `MEVC_OFS_CFG) begin
          cfg_reg[k] <= pwdata_in & `MEVC_CFG_MASK;
        end
        // The low-half read freezes all 32 bits for the later high read
        if (rd_w && is_ch_w && ach_w == k[1:0] && aofs_w == `MEVC_OFS_LO) begin
          snap_reg[k] <= cnt_reg[k];
        end
        // Latch source: mapped input edge or the start-of-scan strobe
        if (cfg_reg[k][`MEVC_F_LMAP]) begin
          if (rise_w[cfg_reg[k][`MEVC_F_MAP]]) begin
            latch_reg[k] <= cnt_reg[k];
          end
        end else if (scan_start_in) begin
          latch_reg[k] <= cnt_reg[k];
        end
      end
    end
  end

  // Sample slot port: one 16-bit half per slot, so 32 bits take two
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      slot_data_out <= 16'h0000;
      slot_valid_out <= 1'b0;
    end else begin
      slot_valid_out <= slot_req_in;
      if (slot_req_in) begin
        if (slot_hi_in) begin
          slot_data_out <= latch_reg[slot_ch_in][31:16];
        end else begin
          slot_data_out <= latch_reg[slot_ch_in][15:0];
        end
      end
    end
  end

endmodule

// ===== design/mevc_debounce.v
// One input conditioning path: optional inverter, then debounce or bypass.
// Input is synchronous to clk_in; limit_in is the interval in clock cycles.
`timescale 1ns/1ps
`include "mevc_map.vh"

module mevc_debounce (
  // Clock and reset
  input wire clk_in,
  input wire rstn_in,
  // Raw input and settings
  input wire raw_in,
  input wire invert_in,
  input wire [1:0] mode_in,
  input wire [`MEVC_DB_TW-1:0] limit_in,
  // Conditioned output
  output wire cond_out
);

  wire inv_w;
  wire stable_w;
  reg last_reg;
  reg out_reg;
  reg [`MEVC_DB_TW-1:0] tmr_reg;

  assign inv_w = raw_in ^ invert_in;
  assign stable_w = (tmr_reg >= limit_in);
  // Bypass skips the timer entirely, so glitches reach the counter
  assign cond_out = (mode_in == `MEVC_DB_BYPASS) ? inv_w : out_reg;

  // Timer restarts on every level change and saturates at the limit
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      last_reg <= 1'b0;
      tmr_reg <= {`MEVC_DB_TW{1'b0}};
      out_reg <= 1'b0;
    end else begin
      last_reg <= inv_w;
      if (inv_w != last_reg) begin
        tmr_reg <= {`MEVC_DB_TW{1'b0}};
      end else if (!stable_w) begin
        tmr_reg <= tmr_reg + 1'b1;
      end
      case (mode_in)
        `MEVC_DB_AFTER: begin
          if (stable_w && out_reg != last_reg) begin
            out_reg <= last_reg;
          end
        end
        `MEVC_DB_BEFORE: begin
          if (stable_w && inv_w != last_reg) begin
            out_reg <= inv_w;
          end else if (stable_w) begin
            out_reg <= last_reg;
          end
        end
        default: begin
          out_reg <= inv_w;
        end
      endcase
    end
  end

endmodule

// ===== design/mevc_map.vh
// Constants for the four-channel event counter bank: register map,
// configuration fields, reset values and debounce timing.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
//
// Functional notes
// - Four independent 32-bit counters, each counting input pulses up to 5 MHz.
// - In synchronous scan use, every counter clears when an acquisition begins.
// - Each counter picks a mapped input from any of four debounced inputs.
// - Start-of-scan latches the count; latch-on-map lets mapped edges latch instead.
// - Reading the low half captures 32 bits; high half read returns captured part.
// - Totalize counts up (down on mapped edges with decrement), keeps value on sampling, clears when an acquisition begins.
// - Totalize wraps at 16 bits as low word and at 32 bits as full.
// - A 32-bit scanned result uses two sample slots; a lone half uses one.
// - Clear-on-read counts up, clears on read, returns the value before clearing.
// - Clear-on-read works on asynchronous reads only; low half first, then high.
// - Stop-at-top saturates at FFFF (16-bit) or FFFFFFFF (32-bit).
// - The 16/32 width setting matters only in stop-at-top mode.
// - With gating, count only while the mapped input is high; otherwise hold.
// - With decrement, own input edges count up and mapped input edges count down.
// - Sixteen debounce interval settings span 500 ns to 25.5 ms.
// - An optional inverter before debounce selects the active edge.
// - Bypass ignores the interval and passes the inverter output straight on.
// - Conditioning offers stable-then-accept, accept-then-hold, and bypass.
// - Stable-then-accept changes output only after the full uninterrupted interval.
// - Accept-then-hold passes an edge after stability, then blocks until stable again.
`ifndef MEVC_MAP_VH
`define MEVC_MAP_VH

// Register map: channel n block at n * stride, global control after
`define MEVC_CH_STRIDE 8'h10
`define MEVC_OFS_CFG 2'h0
`define MEVC_OFS_LO 2'h1
`define MEVC_OFS_HI 2'h2
`define MEVC_OFS_LATCH 2'h3
`define MEVC_ADDR_CTRL 8'h40

// Configuration register fields
`define MEVC_F_MODE 1:0
`define MEVC_F_W32 2
`define MEVC_F_LMAP 3
`define MEVC_F_GATE 4
`define MEVC_F_DEC 5
`define MEVC_F_MAP 7:6
`define MEVC_F_INV 8
`define MEVC_F_DBM 10:9
`define MEVC_F_DBT 14:11
`define MEVC_CFG_MASK 32'h00007FFF
`define MEVC_CFG_RST 32'h00000400
`define MEVC_F_SYNC 0

// Counter modes
`define MEVC_MODE_TOT 2'h0
`define MEVC_MODE_COR 2'h1
`define MEVC_MODE_SAT 2'h2

// Debounce modes
`define MEVC_DB_AFTER 2'h0
`define MEVC_DB_BEFORE 2'h1
`define MEVC_DB_BYPASS 2'h2

// Saturation tops
`define MEVC_TOP16 32'h0000FFFF
`define MEVC_TOP32 32'hFFFFFFFF

// Timing: clock period and debounce intervals in nanoseconds
`define MEVC_CLK_NS 100
`define MEVC_DB_T0_NS 500
`define MEVC_DB_T1_NS 1000
`define MEVC_DB_T2_NS 2000
`define MEVC_DB_T3_NS 5000
`define MEVC_DB_T4_NS 10000
`define MEVC_DB_T5_NS 20000
`define MEVC_DB_T6_NS 50000
`define MEVC_DB_T7_NS 100000
`define MEVC_DB_T8_NS 200000
`define MEVC_DB_T9_NS 500000
`define MEVC_DB_T10_NS 1000000
`define MEVC_DB_T11_NS 2000000
`define MEVC_DB_T12_NS 5000000
`define MEVC_DB_T13_NS 10000000
`define MEVC_DB_T14_NS 20000000
`define MEVC_DB_T15_NS 25500000
`define MEVC_DB_TW 18

`endif

// ===== dv/mevc_bank_assertions.sv
// Concurrent checks on the counter bank's APB and sample slot ports.
// Sees only the top module's ports; attached by bind below.
`timescale 1ns/1ps
module mevc_bank_assertions (
  // Clock and reset
  input wire clk_in,
  input wire rstn_in,
  // APB
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  // Sample slot
  input wire slot_req_in,
  input wire slot_valid_out
);
  // Access phase and upper-half reads
  wire acc = psel_in && penable_in;
  wire hi_rd = acc && !pwrite_in && paddr_in[3:0] == 4'h8 && paddr_in < 8'h40;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_READY: assert property (acc |-> pready_out)
    else $error("ready missing in access");
  AST_MISALIGN: assert property (acc && paddr_in[1:0] != 2'h0 |-> pslverr_out)
    else $error("misaligned access not refused");
  AST_UNMAPPED: assert property (acc && paddr_in > 8'h40 |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  AST_NOERR_IDLE: assert property (!acc |-> !pslverr_out)
    else $error("error outside access");
  AST_SLOT_VALID: assert property (slot_req_in |=> slot_valid_out)
    else $error("slot answer missing");
  AST_SLOT_ONLY: assert property (slot_valid_out |-> $past(slot_req_in))
    else $error("slot answer without request");
  // A repeated upper read must show the same captured half
  AST_HI_SNAP: assert property (hi_rd && $past(hi_rd, 3) && paddr_in == $past(paddr_in, 3)
    && $past(rstn_in, 3) && $past(rstn_in, 2) && $past(rstn_in)
    |-> prdata_out == $past(prdata_out, 3))
    else $error("upper half changed without lower read");
  AST_CFG_FIELDS: assert property (acc && !pwrite_in && paddr_in[3:0] == 4'h0
    && paddr_in < 8'h40 |-> prdata_out[31:15] == 17'h0)
    else $error("config reads unused bits");
  C_ERR: cover property (acc && pslverr_out);
  C_SLOT: cover property (slot_valid_out);
  C_HI: cover property (hi_rd);
endmodule

bind mevc_bank mevc_bank_assertions mevc_bank_assertions_inst (.clk_in(clk_in),
  .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .slot_req_in(slot_req_in), .slot_valid_out(slot_valid_out));

// ===== dv/mevc_src.sv
// Pulse source standing in for a switch or pick-up on one counter input.
// Assumes commands from the bench on its clock; output is a pushed level.
`timescale 1ns/1ps
module mevc_src (
  // Clock
  input wire clk_in,
  // Command
  input wire go_in,
  input wire [7:0] n_in,
  input wire [7:0] w_in,
  // Pulse line
  output reg pin_out
);
  // Idle low; phases never under one clock, since shorter ones are lost
  initial pin_out = 1'b0;
  always begin
    @(posedge clk_in);
    if (go_in) begin
      repeat (n_in) begin
        pin_out <= 1'b1;
        repeat (w_in) @(posedge clk_in);
        pin_out <= 1'b0;
        repeat (w_in) @(posedge clk_in);
      end
    end
  end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the four-channel counter bank.
// Assumes the bank, its checker and the pulse source are compiled first.
`timescale 1ns/1ps
module tb;
  reg clk_in = 0;
  reg rstn_in = 0;
  reg psel = 0, pen = 0, pwr = 0, scan = 0, acq = 0, sreq = 0, shi = 0;
  reg [7:0] paddr = 0, n = 0, w = 0;
  reg [31:0] pwdata = 0, rd_v;
  reg [1:0] sch = 0;
  reg [3:0] go = 0;
  reg rd_e;
  wire [31:0] prdata;
  wire [15:0] sdata;
  wire [3:0] pins;
  wire prdy, perr, svalid;
  integer miscompares = 0;
  integer comparisons = 0;
  integer cyc = 0;

  initial forever #50 clk_in = ~clk_in;

  // Debounce counts shortened a thousandfold
  mevc_bank #(.DB_DIV(1000)) mevc_bank_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr),
    .cnt_pin_in(pins), .scan_start_in(scan), .acq_start_in(acq), .slot_req_in(sreq),
    .slot_ch_in(sch), .slot_hi_in(shi), .slot_data_out(sdata), .slot_valid_out(svalid));
  mevc_src mevc_src_inst [3:0] (.clk_in(clk_in), .go_in(go), .n_in(n), .w_in(w),
    .pin_out(pins));

  task chk(input string nm, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // One APB transfer; waits for ready, takes data at the falling edge where ready is seen
  task apb(input wr, input [7:0] a, input [31:0] d);
    @(posedge clk_in);
    psel <= 1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1;
    // Look mid-cycle, where the answer stands before the edge that takes it
    @(negedge clk_in);
    while (prdy !== 1'b1) @(negedge clk_in);
    rd_v = prdata;
    rd_e = perr;
    @(posedge clk_in);
    psel <= 0;
    pen <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    apb(0, a, 32'h0);
    chk("prdata", e, rd_v);
  endtask
  task pulse(input [1:0] c, input [7:0] k, input [7:0] t);
    @(posedge clk_in);
    go[c] <= 1;
    n <= k;
    w <= t;
    @(posedge clk_in);
    go[c] <= 0;
    repeat (2 * k * t + 6) @(posedge clk_in);
  endtask
  task clr;
    @(posedge clk_in);
    acq <= 1;
    @(posedge clk_in);
    acq <= 0;
  endtask
  task slot(input [1:0] c, input h, input [15:0] e);
    @(posedge clk_in);
    sreq <= 1;
    sch <= c;
    shi <= h;
    @(posedge clk_in);
    sreq <= 0;
    // The answer stands for one cycle only; sample it mid-cycle
    @(negedge clk_in);
    chk("slot_valid", 32'h1, {31'h0, svalid});
    chk("slot_data", {16'h0, e}, {16'h0, sdata});
  endtask

  task t_reset;
    rd(8'h00, 32'h00000400);
    rd(8'h40, 32'h0);
    apb(0, 8'h50, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rd_e});
    apb(1, 8'h01, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rd_e});
    apb(1, 8'h04, 32'h00001234);
    rd(8'h04, 32'h0);
  endtask
  task t_total;
    pulse(0, 5, 2);
    rd(8'h04, 32'h5);
    rd(8'h04, 32'h5);
    rd(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    @(posedge clk_in);
    scan <= 1;
    @(posedge clk_in);
    scan <= 0;
    rd(8'h0C, 32'h5);
    slot(0, 0, 16'h0005);
    slot(0, 1, 16'h0000);
    clr;
    rd(8'h04, 32'h0);
  endtask
  task t_cor;
    apb(1, 8'h10, 32'h00000401);
    pulse(1, 3, 1);
    rd(8'h14, 32'h3);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h0);
    apb(1, 8'h40, 32'h1);
    pulse(1, 2, 1);
    rd(8'h14, 32'h2);
    rd(8'h14, 32'h2);
    apb(1, 8'h40, 32'h0);
  endtask
  task t_gate;
    apb(1, 8'h00, 32'h00000450);
    apb(1, 8'h10, 32'h00000500);
    clr;
    pulse(0, 2, 2);
    rd(8'h04, 32'h2);
    apb(1, 8'h10, 32'h00000400);
    pulse(0, 3, 2);
    rd(8'h04, 32'h2);
  endtask
  task t_sat;
    apb(1, 8'h20, 32'h000004E6);
    clr;
    pulse(3, 1, 2);
    rd(8'h24, 32'h0000FFFF);
    rd(8'h28, 32'h0000FFFF);
    pulse(2, 2, 2);
    rd(8'h24, 32'h0000FFFF);
    rd(8'h28, 32'h0000FFFF);
  endtask
  task t_deb;
    apb(1, 8'h30, 32'h00006800);
    clr;
    pulse(3, 1, 10);
    rd(8'h34, 32'h0);
    pulse(3, 1, 150);
    rd(8'h34, 32'h1);
    apb(1, 8'h30, 32'h00006A00);
    clr;
    pulse(3, 3, 5);
    rd(8'h34, 32'h1);
  endtask

  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up;
    end
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1;
    t_reset;
    t_total;
    t_cor;
    t_gate;
    t_sat;
    t_deb;
    wrap_up;
  end
endmodule
